// *** rtl/sar_seq_defines.svh ***
// register map, field positions and fixed values of the sar sequencer
`ifndef SAR_SEQ_DEFINES_SVH
`define SAR_SEQ_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTL0 8'h00
`define OFF_CTL1 8'h04
`define OFF_IE 8'h08
`define OFF_IFG 8'h0C
`define OFF_IV 8'h10
`define OFF_SLOT_HI 2'h1
`define OFF_RES_HI 2'h2
// ----------------------------------------
// control word 0 fields
// ----------------------------------------
`define C0_SHT 11:8
`define C0_OVIE 3
`define C0_TOVIE 2
`define C0_ENABLE 1
`define C0_START 0
`define C0_MASK 16'h0F0F
`define C0_LOCKED 16'h0F00
// ----------------------------------------
// control word 1 fields
// ----------------------------------------
`define C1_START_ADDR 15:12
`define C1_SRC 11:10
`define C1_PULSE 9
`define C1_INVERT 8
`define C1_DIV 7:5
`define C1_CLKSEL 4:3
`define C1_MODE 2:1
`define C1_BUSY 0
`define C1_MASK 16'hFFFE
// ----------------------------------------
// vector values, bus answers and sample-time cycle table
// ----------------------------------------
`define IV_NONE 16'h0000
`define IV_OVERFLOW 16'h0002
`define IV_TIME_OV 16'h0004
`define IV_SLOT0 16'h0006
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SHT_CYCLES '{11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h060, 11'h080, \
  11'h0C0, 11'h100, 11'h180, 11'h200, 11'h300, 11'h400, 11'h400, 11'h400, 11'h400}
`endif

// *** rtl/sar_seq_pkg.sv ***
// types shared by the sar sequencer design files
package sar_seq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_SEQUENCE, MODE_REPEAT_SINGLE, MODE_REPEAT_SEQUENCE
  } sequence_mode_type;
  typedef enum {
    ST_IDLE, ST_ARMED, ST_NEXT, ST_SAMPLE, ST_CONVERT
  } seq_state_type;
  typedef enum {
    SEL_CTL0, SEL_CTL1, SEL_IE, SEL_IFG, SEL_IV, SEL_SLOT, SEL_RES, SEL_NONE
  } reg_sel_type;
  typedef struct packed {
    logic last_in_sequence;
    logic [2:0] reference_select;
    logic [3:0] channel_select;
  } slot_control_type;
  typedef struct packed {
    logic sampling_control_signal;
    logic conv_start;
    logic [2:0] reference_select;
    logic [3:0] channel_select;
  } core_req_type;
endpackage

// *** rtl/result_mem.sv ***
// result slot storage with a registered read port
module result_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input logic core_clk,
  input logic nrst,
  // write port
  input logic we,
  input logic [$clog2(DEPTH)-1:0] waddr,
  input logic [WIDTH-1:0] wdata,
  // read port
  input logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // storage has no reset: contents stand unchanged over reset
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data from a register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// *** rtl/conv_clock_gen.sv ***
// conversion clock source select and divider, as a tick on core_clk
module conv_clock_gen #(
  parameter int SOURCES = 4
) (
  // clock and reset
  input logic core_clk,
  input logic nrst,
  // source clocks from other domains
  input logic [SOURCES-1:0] src_clk,
  // configuration
  input logic [1:0] conv_clock_source,
  input logic [2:0] conv_clock_divider,
  // one cycle per conversion clock period
  output logic conv_tick
);
  logic [SOURCES-1:0] meta_reg;
  logic [SOURCES-1:0] sync_reg;
  logic [SOURCES-1:0] prev_reg;
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic src_edge;
  logic tick_reg;

  // two flops per source, then an edge stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= src_clk;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign src_edge = sync_reg[conv_clock_source] & ~prev_reg[conv_clock_source];
  assign div_next = (div_reg >= conv_clock_divider) ? 3'h0 : 3'(div_reg + 3'h1);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= src_edge & (div_reg >= conv_clock_divider);
      if (src_edge) begin
        div_reg <= div_next;
      end
    end
  end
  assign conv_tick = tick_reg;
endmodule

// *** rtl/sar_converter_sequencer_regs.sv ***
// register file and sequencer around a 12-bit sar converter core
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`include "sar_seq_defines.svh"
// Behaviour
// - pulse-mode bit 9 picks sample input (0) or sampling timer (1)
// - invert bit 8 inverts the sample input when set
// - divider bits 7-5 divide the source clock by value plus one
// - bits 4-3 pick oscillator, auxiliary, main or sub-main clock
// - bits 2-1 pick single, sequence, repeat single, repeat sequence
// - busy bit 0 reads 1 while a sequence, sample or conversion runs
// - results are 12 bits right-justified; bits 15-12 read zero
// - slot control bytes only change while conversion enable is 0
// - slot bit 7 marks the last slot; sequencer stops or wraps after it
// - slot bits 6-4 pick one of eight reference pairs
// - slot bits 3-0 pick external input, reference, sensor or half supply
// - each enable bit gates its slot flag request
// - a slot flag sets when its result is loaded
// - a slot flag clears on result access or software write
// - vector: 0 none, 2 overflow, 4 time overflow, 6+2n slot n
// - enable bit permits conversion; config locked while it is 1
// - bits 11-10 pick trigger: 00 software start, others timers
// - sampling timer holds 4 to 1024 conversion clocks per code
module sar_converter_sequencer_regs #(
  parameter int SLOTS = 16,
  parameter int RES_W = 12
) (
  // clock and reset
  input logic core_clk,
  input logic nrst,
  // axi4-lite write address and data
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // axi4-lite read
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  // conversion clock sources and timer triggers
  input logic [3:0] conv_src_clk,
  input logic [2:0] trig_in,
  // analog core
  output sar_seq_pkg::core_req_type core_req,
  output logic conversion_clock,
  input logic conv_done,
  input logic [RES_W-1:0] conv_result,
  // status
  output logic converter_busy
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [10:0] sht_table [16];
  logic [15:0] ctl0_reg;
  logic [15:0] ctl1_reg;
  logic [15:0] ie_reg;
  logic [15:0] ifg_reg;
  logic [15:0] ifg_next;
  logic ov_reg;
  logic tov_reg;
  sar_seq_pkg::slot_control_type slot_reg [SLOTS];
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;
  logic [15:0] iv_snap_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [2:0] trig_meta_reg;
  logic [2:0] trig_sync_reg;
  logic sample_prev_reg;
  sar_seq_pkg::seq_state_type state_reg;
  sar_seq_pkg::seq_state_type state_next;
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic start_pulse_reg;
  logic wr_fire;
  logic ar_fire;
  sar_seq_pkg::reg_sel_type wr_sel;
  sar_seq_pkg::reg_sel_type rd_sel;
  sar_seq_pkg::reg_sel_type ar_sel;
  logic [15:0] wr_val;
  logic enable;
  logic sw_start;
  logic sample_raw;
  logic sample_in;
  logic sample_rise;
  logic store;
  logic go_convert;
  logic seq_end;
  logic [15:0] store_vec;
  logic [15:0] access_clr;
  logic [15:0] pending;
  logic [15:0] iv_value;
  logic [15:0] rd_word;
  logic [RES_W-1:0] mem_rdata;
  logic [3:0] mem_raddr;
  logic [3:0] mem_waddr;
  logic [RES_W-1:0] mem_wdata;
  logic mem_we;
  sar_seq_pkg::slot_control_type cur_slot;
  sar_seq_pkg::sequence_mode_type mode;

  assign sht_table = `SHT_CYCLES;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // address to register select
  function automatic sar_seq_pkg::reg_sel_type decode(input logic [7:0] a);
    if (a[7:6] == `OFF_SLOT_HI) begin
      decode = sar_seq_pkg::SEL_SLOT;
    end else if (a[7:6] == `OFF_RES_HI) begin
      decode = sar_seq_pkg::SEL_RES;
    end else begin
      case (a)
        `OFF_CTL0: decode = sar_seq_pkg::SEL_CTL0;
        `OFF_CTL1: decode = sar_seq_pkg::SEL_CTL1;
        `OFF_IE: decode = sar_seq_pkg::SEL_IE;
        `OFF_IFG: decode = sar_seq_pkg::SEL_IFG;
        `OFF_IV: decode = sar_seq_pkg::SEL_IV;
        default: decode = sar_seq_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  // address and data are held independently, the write acts when both are in
  assign awready = ~aw_held_reg;
  assign wready = ~w_held_reg;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign arready = ~rd_pend_reg & ~rvalid_reg;
  assign ar_fire = arvalid & arready;
  assign wr_sel = decode(aw_addr_reg);
  assign ar_sel = decode(araddr);
  assign rd_sel = decode(rd_addr_reg);
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_sel == sar_seq_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read: address taken, data registered on the next edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      iv_snap_reg <= `IV_NONE;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rd_pend_reg <= 1'b1;
        rd_addr_reg <= araddr;
        iv_snap_reg <= iv_value;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= {16'h0000, rd_word};
        rresp_reg <= (rd_sel == sar_seq_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // read word select; result high bits zero
  always_comb begin
    case (rd_sel)
      sar_seq_pkg::SEL_CTL0: rd_word = ctl0_reg;
      sar_seq_pkg::SEL_CTL1: rd_word = {ctl1_reg[15:1], converter_busy};
      sar_seq_pkg::SEL_IE: rd_word = ie_reg;
      sar_seq_pkg::SEL_IFG: rd_word = ifg_reg;
      sar_seq_pkg::SEL_IV: rd_word = iv_snap_reg;
      sar_seq_pkg::SEL_SLOT: rd_word = {8'h00, slot_reg[rd_addr_reg[5:2]]};
      sar_seq_pkg::SEL_RES: rd_word = {{(16 - RES_W){1'b0}}, mem_rdata};
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  assign wr_val = merge(16'h0000, w_data_reg, w_strb_reg);
  assign enable = ctl0_reg[`C0_ENABLE];
  assign mode = sar_seq_pkg::sequence_mode_type'(ctl1_reg[`C1_MODE]);

  // sample time and control word 1 locked while enabled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl0_reg <= 16'h0000;
      ctl1_reg <= 16'h0000;
      ie_reg <= 16'h0000;
    end else begin
      if (wr_fire && wr_sel == sar_seq_pkg::SEL_CTL0) begin
        ctl0_reg <= merge(ctl0_reg, w_data_reg, w_strb_reg) & `C0_MASK
                    & (enable ? ~`C0_LOCKED : 16'hFFFF) | (enable ? ctl0_reg & `C0_LOCKED : 16'h0000);
      end else if (go_convert || !enable) begin
        ctl0_reg[`C0_START] <= 1'b0;
      end
      if (wr_fire && wr_sel == sar_seq_pkg::SEL_CTL1 && !enable) begin
        ctl1_reg <= merge(ctl1_reg, w_data_reg, w_strb_reg) & `C1_MASK;
      end
      if (wr_fire && wr_sel == sar_seq_pkg::SEL_IE) begin
        ie_reg <= merge(ie_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  // slot control writes only while disabled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_reg[i] <= '0;
      end
    end else if (wr_fire && wr_sel == sar_seq_pkg::SEL_SLOT && !enable && w_strb_reg[0]) begin
      slot_reg[aw_addr_reg[5:2]] <= w_data_reg[7:0];
    end
  end

  // ----------------------------------------
  // flags and vector
  // ----------------------------------------
  // set on load; clear on access or write, load wins
  assign store_vec = store ? 16'(1) << ptr_reg : 16'h0000;
  assign access_clr = ((ar_fire && ar_sel == sar_seq_pkg::SEL_RES) ? 16'(1) << araddr[5:2] : 16'h0000)
                    | ((wr_fire && wr_sel == sar_seq_pkg::SEL_RES) ? 16'(1) << aw_addr_reg[5:2] : 16'h0000);
  assign ifg_next = ((wr_fire && wr_sel == sar_seq_pkg::SEL_IFG)
                     ? merge(ifg_reg, w_data_reg, w_strb_reg) : ifg_reg) & ~access_clr | store_vec;
  assign pending = ifg_reg & ie_reg;

  // highest pending source, bits 5-1 only
  always_comb begin
    iv_value = `IV_NONE;
    for (int n = SLOTS - 1; n >= 0; n--) begin
      if (pending[n]) begin
        iv_value = 16'(`IV_SLOT0 + 16'(2 * n));
      end
    end
    if (tov_reg && ctl0_reg[`C0_TOVIE]) begin
      iv_value = `IV_TIME_OV;
    end
    if (ov_reg && ctl0_reg[`C0_OVIE]) begin
      iv_value = `IV_OVERFLOW;
    end
  end

  // overflow flags: set on event, cleared by a vector read naming them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ifg_reg <= 16'h0000;
      ov_reg <= 1'b0;
      tov_reg <= 1'b0;
    end else begin
      ifg_reg <= ifg_next;
      ov_reg <= (store && ifg_reg[ptr_reg])
             | (ov_reg & ~(ar_fire && ar_sel == sar_seq_pkg::SEL_IV && iv_value == `IV_OVERFLOW));
      tov_reg <= (sample_rise && (state_reg == sar_seq_pkg::ST_CONVERT
                                 || (state_reg == sar_seq_pkg::ST_SAMPLE && ctl1_reg[`C1_PULSE])))
              | (tov_reg & ~(ar_fire && ar_sel == sar_seq_pkg::SEL_IV && iv_value == `IV_TIME_OV));
    end
  end

  // ----------------------------------------
  // sample input
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trig_meta_reg <= 3'h0;
      trig_sync_reg <= 3'h0;
      sample_prev_reg <= 1'b0;
    end else begin
      trig_meta_reg <= trig_in;
      trig_sync_reg <= trig_meta_reg;
      // an input already high when the sequencer leaves idle counts as a rising edge
      sample_prev_reg <= sample_in & (state_reg != sar_seq_pkg::ST_IDLE);
    end
  end

  assign sw_start = ctl0_reg[`C0_START];
  assign sample_raw = (ctl1_reg[`C1_SRC] == 2'h0) ? sw_start : trig_sync_reg[ctl1_reg[`C1_SRC] - 2'h1];
  assign sample_in = sample_raw ^ ctl1_reg[`C1_INVERT];
  assign sample_rise = sample_in & ~sample_prev_reg;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign cur_slot = slot_reg[ptr_reg];
  assign store = (state_reg == sar_seq_pkg::ST_CONVERT) && conv_done;
  assign seq_end = cur_slot.last_in_sequence;

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    go_convert = 1'b0;
    case (state_reg)
      sar_seq_pkg::ST_IDLE: begin
        ptr_next = ctl1_reg[`C1_START_ADDR];
        if (enable) begin
          state_next = sar_seq_pkg::ST_ARMED;
        end
      end
      sar_seq_pkg::ST_ARMED, sar_seq_pkg::ST_NEXT: begin
        if (!enable) begin
          state_next = sar_seq_pkg::ST_IDLE;
        // timer started by a rising edge
        end else if (ctl1_reg[`C1_PULSE] ? sample_rise : sample_in) begin
          state_next = sar_seq_pkg::ST_SAMPLE;
          cnt_next = sht_table[ctl0_reg[`C0_SHT]];
        end
      end
      sar_seq_pkg::ST_SAMPLE: begin
        // end of sampling from timer or from the input level
        if (ctl1_reg[`C1_PULSE]) begin
          if (conversion_clock) begin
            cnt_next = 11'(cnt_reg - 11'h001);
            go_convert = (cnt_reg == 11'h001);
          end
        end else begin
          go_convert = ~sample_in;
        end
        if (go_convert) begin
          state_next = sar_seq_pkg::ST_CONVERT;
        end
      end
      sar_seq_pkg::ST_CONVERT: begin
        if (conv_done) begin
          case (mode)
            sar_seq_pkg::MODE_SINGLE: state_next = sar_seq_pkg::ST_ARMED;
            sar_seq_pkg::MODE_REPEAT_SINGLE: state_next = sar_seq_pkg::ST_NEXT;
            sar_seq_pkg::MODE_SEQUENCE: begin
              state_next = seq_end ? sar_seq_pkg::ST_ARMED : sar_seq_pkg::ST_NEXT;
              ptr_next = seq_end ? ctl1_reg[`C1_START_ADDR] : 4'(ptr_reg + 4'h1);
            end
            default: begin
              state_next = sar_seq_pkg::ST_NEXT;
              ptr_next = seq_end ? ctl1_reg[`C1_START_ADDR] : 4'(ptr_reg + 4'h1);
            end
          endcase
        end
      end
      default: state_next = sar_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= sar_seq_pkg::ST_IDLE;
      ptr_reg <= 4'h0;
      cnt_reg <= 11'h000;
      start_pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      start_pulse_reg <= go_convert;
    end
  end

  // busy while sampling, converting or mid-sequence
  assign converter_busy = (state_reg == sar_seq_pkg::ST_SAMPLE)
                        | (state_reg == sar_seq_pkg::ST_CONVERT)
                        | (state_reg == sar_seq_pkg::ST_NEXT);

  // slot reference and channel to the core
  assign core_req = {(state_reg == sar_seq_pkg::ST_SAMPLE), start_pulse_reg,
                     cur_slot.reference_select, cur_slot.channel_select};

  // ----------------------------------------
  // result storage and clock
  // ----------------------------------------
  // conversion load wins the write port over a software write
  assign mem_we = store | (wr_fire && wr_sel == sar_seq_pkg::SEL_RES);
  assign mem_waddr = store ? ptr_reg : aw_addr_reg[5:2];
  assign mem_wdata = store ? conv_result : wr_val[RES_W-1:0];
  assign mem_raddr = ar_fire ? araddr[5:2] : rd_addr_reg[5:2];

  result_mem #(
    .WIDTH(RES_W),
    .DEPTH(SLOTS)
  ) i_result_mem (
    .core_clk(core_clk),
    .nrst(nrst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  conv_clock_gen #(
    .SOURCES(4)
  ) i_conv_clock_gen (
    .core_clk(core_clk),
    .nrst(nrst),
    .src_clk(conv_src_clk),
    .conv_clock_source(ctl1_reg[`C1_CLKSEL]),
    .conv_clock_divider(ctl1_reg[`C1_DIV]),
    .conv_tick(conversion_clock)
  );
endmodule

// *** sim/sar_seq_sva.sv ***
// concurrent checks on the ports of the sar sequencer register block
module sar_seq_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bus handshakes
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  // core side and status
  input wire sar_seq_pkg::core_req_type core_req,
  input wire logic converter_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // start strobe lasts exactly one cycle
  sequence start_pulse;
    core_req.conv_start ##1 !core_req.conv_start;
  endsequence
  chk_samp_busy: assert property (core_req.sampling_control_signal |-> converter_busy)
    else $error("sampling while not busy");
  chk_start_busy: assert property (core_req.conv_start |-> converter_busy)
    else $error("conversion start while not busy");
  chk_start_once: assert property (core_req.conv_start |-> start_pulse)
    else $error("conversion start longer than one cycle");
  chk_start_after: assert property (
    $fell(core_req.sampling_control_signal) |-> ##[0:2] core_req.conv_start)
    else $error("no conversion start after sampling");
  chk_rdata_top: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_read_single: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  chk_read_block: assert property (rvalid |-> !arready)
    else $error("read address taken during answer");
  chk_write_single: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
endmodule
bind sar_converter_sequencer_regs sar_seq_sva i_sar_seq_sva (.core_clk, .nrst, .arready,
  .rvalid, .rready, .rdata, .bvalid, .bready, .core_req, .converter_busy);

// *** sim/sar_core_model.sv ***
// behavioural model of the analog sar core on the far side
module sar_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // answer speed
  input wire logic slow,
  // requests and answers
  input wire sar_seq_pkg::core_req_type core_req,
  output logic conv_done,
  output logic [11:0] conv_result
);
  int cnt;
  // count down the conversion time, then answer with a coded result
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result; // stale result never holds
      if (core_req.conv_start) begin
        cnt <= slow ? 20 : 1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_done <= 1'b1;
        conv_result <= {4'hA, 1'b0, core_req.reference_select, core_req.channel_select};
      end
    end
  end
endmodule

// *** sim/sar_converter_sequencer_regs_bench.sv ***
// self-checking bench of the sar sequencer register block
module sar_converter_sequencer_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
  int errors = 0, tests_run = 0, cyc = 0;
  logic core_clk, nrst, awvalid, wvalid, bready, arvalid, rready, slow, awready, wready;
  logic bvalid, arready, rvalid, conv_done, conversion_clock, converter_busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb, conv_src_clk;
  logic [2:0] trig_in;
  logic [1:0] bresp, rresp;
  logic [11:0] conv_result;
  sar_seq_pkg::core_req_type core_req;
  logic [7:0] row_a [10] = '{8'h08, 8'h08, 8'h40, 8'h7C, 8'h10, 8'h04, 8'h04, 8'h04, 8'h04,
    8'h04};
  logic [31:0] row_w [10] = '{32'hFFFF, 32'h1, 32'hBA, 32'hFF, 32'hFFFF, 32'hFFFF, 32'h2,
    32'h4, 32'h6, 32'h200};
  logic [31:0] row_e [10] = '{32'hFFFF, 32'h1, 32'hBA, 32'hFF, 32'h0, 32'hFFFE, 32'h2,
    32'h4, 32'h6, 32'h200};
  sar_converter_sequencer_regs i_sar_converter_sequencer_regs (.core_clk, .nrst, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .conv_src_clk, .trig_in,
    .core_req, .conversion_clock, .conv_done, .conv_result, .converter_busy);
  sar_core_model i_sar_core_model (.core_clk, .nrst, .slow, .core_req, .conv_done,
    .conv_result);
  // verdict and end of run
  task test_done;
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one axi4-lite write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1) errors++;
  endtask
  // one axi4-lite read, data kept in rd_val
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1) errors++;
    rd_val = rdata;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // source clocks and hang guard
  always @(posedge core_clk) begin
    cyc++;
    conv_src_clk <= conv_src_clk + 4'h1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    {nrst, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, slow, wstrb, conv_src_clk, trig_in} = {3'b111, 4'hF, 4'h0, 3'h0};
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i));
      `CHK(rd_val, 32'h0)
    end
    rd(8'h20);
    `CHK(rresp, 2'h2)
    for (int i = 0; i < 10; i++) begin
      wr(row_a[i], row_w[i]);
      rd(row_a[i]);
      `CHK(rd_val, row_e[i])
    end
    wr(8'h00, 32'h3);
    repeat (4) @(posedge core_clk);
    `CHK(converter_busy, 1'b1)
    `CHK(core_req, 9'h13A)
    rd_val = '0;
    for (int i = 0; i < 100 && rd_val[0] !== 1'b1; i++) rd(8'h0C);
    `CHK(rd_val, 32'h1)
    wr(8'h40, 32'h0);
    rd(8'h40);
    `CHK(rd_val, 32'hBA)
    rd(8'h10);
    `CHK(rd_val, 32'h6)
    // result slots are only ever read by this bench
    rd(8'h80);
    `CHK(rd_val, 32'hA3A)
    rd(8'h0C);
    `CHK(rd_val, 32'h0)
    rd(8'h10);
    `CHK(rd_val, 32'h0)
    // reset in mid-run: registers clear, results stay
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h00);
    `CHK(rd_val, 32'h0)
    rd(8'h80);
    `CHK(rd_val, 32'hA3A)
    // timer trigger 1, inverted, sampling follows its level
    wr(8'h04, 32'h500);
    wr(8'h00, 32'h2);
    repeat (4) @(posedge core_clk);
    `CHK(converter_busy, 1'b1)
    trig_in <= 3'h1;
    rd_val = '0;
    for (int i = 0; i < 100 && rd_val[0] !== 1'b1; i++) rd(8'h0C);
    `CHK(rd_val, 32'h1)
    rd(8'h10);
    `CHK(rd_val, 32'h0)
    rd(8'h80);
    `CHK(rd_val, 32'hA00)
    test_done();
  end
endmodule
